// >>> drive_cycle_param_pkg.sv
// constants, carriers and state layout for the cycle and parameter checker
// assumes one 100 MHz core clock; parameter identifiers arrive as plain 16-bit numbers
package drive_cycle_param_pkg;
   localparam int NUM_REQ = 11;
   localparam logic [15:0] PID_CTL_CYC = 16'h0001;
   localparam logic [15:0] PID_COMM_CYC = 16'h0002;
   localparam logic [15:0] PID_REPLY_TX = 16'h0006;
   localparam logic [15:0] PID_FB_CAP = 16'h0007;
   localparam logic [15:0] PID_CMD_VALID = 16'h0008;
   localparam logic [15:0] PID_MASTER_POS = 16'h0009;
   localparam logic [15:0] PID_TEL_TYPE = 16'h000F;
   localparam logic [15:0] PID_REPLY_CFG = 16'h0010;
   localparam logic [15:0] PID_MASTER_CFG = 16'h0018;
   localparam logic [15:0] PID_MASTER_TX = 16'h0059;
   localparam logic [15:0] PID_PH3_CHECK = 16'h007F;
   localparam logic [15:0] PID_POS_TYPE = 16'h004C;
   localparam logic [15:0] PID_POS_FACTOR = 16'h004D;
   localparam logic [15:0] PID_POS_EXP = 16'h004E;
   localparam logic [15:0] REQ_PID [NUM_REQ] = '{PID_CTL_CYC, PID_COMM_CYC,
      PID_REPLY_TX, PID_FB_CAP, PID_CMD_VALID, PID_MASTER_POS, PID_TEL_TYPE,
      PID_REPLY_CFG, PID_MASTER_CFG, PID_MASTER_TX, PID_PH3_CHECK};
   localparam int CHK_IX = 10;
   localparam logic [NUM_REQ-1:0] PEND_RST = 11'h7FF;
   // cycle periods in microseconds
   localparam logic [31:0] CYC_62US = 32'h0000_003E;
   localparam logic [31:0] CYC_125US = 32'h0000_007D;
   localparam logic [31:0] CYC_250US = 32'h0000_00FA;
   localparam logic [31:0] CYC_500US = 32'h0000_01F4;
   localparam logic [31:0] CYC_1MS = 32'h0000_03E8;
   localparam logic [31:0] CYC_MAX = 32'h0000_FDE8;
   localparam logic [1:0] GRAN_NONE = 2'h0;
   localparam logic [1:0] GRAN_ONE = 2'h1;
   localparam logic [1:0] GRAN_TWO = 2'h2;
   localparam logic [1:0] GRAN_THREE = 2'h3;
   localparam logic [2:0] PHASE_TWO = 3'h2;
   localparam logic [2:0] PHASE_THREE = 3'h3;
   // position scaling type word
   localparam int SCL_TYPE_LSB = 0;
   localparam int SCL_UNIT_BIT = 4;
   localparam logic [2:0] SCL_NONE = 3'h0;
   localparam logic [2:0] SCL_LINEAR = 3'h1;
   localparam logic [15:0] POS_TYPE_RST = 16'h0001;
   localparam logic [31:0] POS_FACTOR_RST = 32'h0000_0001;
   localparam logic [15:0] POS_EXP_RST = 16'hFFF9;
   localparam logic [15:0] POS_EXP_INCH_PREF = 16'hFFFA;
   // internal position unit is 1 nm; one inch is 254 * 10^5 nm
   localparam logic [15:0] INT_EXP_METRE = 16'h0009;
   localparam logic [15:0] INT_EXP_INCH = 16'h0005;
   localparam logic [31:0] INCH_MULT = 32'h0000_00FE;
   localparam int POW_MAX = 9;

   typedef struct packed {
      logic valid;
      logic [15:0] pid;
      logic [31:0] data;
   } param_wr_s;

   typedef struct packed {
      logic ack;
      logic reject;
   } wr_resp_s;

   typedef struct packed {
      logic pass;
      logic fail;
   } phase_chk_s;

   typedef struct packed {
      logic [2:0] prevPhase;
      logic [NUM_REQ-1:0] pending;
      logic [15:0] firstInvalid;
      logic listEmpty;
      logic [31:0] commCyc;
      logic [31:0] ctlCyc;
      logic [15:0] posType;
      logic [31:0] posFactor;
      logic [15:0] posExp;
      wr_resp_s resp;
      phase_chk_s chk;
      logic [31:0] posToMaster;
      logic [31:0] cmdPosInternal;
   } core_state_s;
endpackage

// >>> cycle_period_check.sv
// validity of a communication cycle period against the granularity sets
// assumes period in microseconds; result is combinational
`timescale 1ns/10ps
module cycle_period_check
   import drive_cycle_param_pkg::*;
(
   input wire logic [31:0] period,
   input wire logic [1:0] gran,
   output logic periodOk
);
   logic [31:0] step;
   logic shortOk;

   always_comb begin
      unique case (gran)
         GRAN_TWO: begin
            step = CYC_500US;
         end
         GRAN_THREE: begin
            step = CYC_250US;
         end
         default: begin
            step = CYC_1MS;
         end
      endcase
      // short periods below 1 ms are listed one by one, whatever the step
      shortOk = (period == CYC_62US) || (period == CYC_125US) ||
         (period == CYC_250US) || (period == CYC_500US);
      periodOk = shortOk ||
         ((period >= step) && (period <= CYC_MAX) && ((period % step) == 32'h0000_0000));
   end
endmodule

// >>> drive_cycle_param.sv
// parameter write acceptance, phase-two invalid list, cycle check, position scaling
// assumes the service channel hands one parameter write per valid cycle
`timescale 1ns/10ps
module drive_cycle_param
   import drive_cycle_param_pkg::*;
#(
   parameter int POS_W = 32
)
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [2:0] phase,
   input wire logic [1:0] gran,
   input wire param_wr_s wrReq,
   output wr_resp_s wrResp,
   output phase_chk_s phaseChk,
   output logic [NUM_REQ-1:0] invalidMask,
   output logic [15:0] firstInvalid,
   output logic listEmpty,
   output logic [31:0] commCycle,
   input wire logic [POS_W-1:0] internalPos,
   output logic [POS_W-1:0] posToMaster,
   input wire logic [POS_W-1:0] cmdPosIn,
   output logic [POS_W-1:0] cmdPosInternal
);
   core_state_s cur_ff;
   core_state_s nxt_ff;
   logic cycOk;
   logic reqHit;
   logic [3:0] reqIx;
   logic phaseOk;
   logic [15:0] powIdx;
   logic [63:0] pow;
   logic [63:0] divisor;
   logic [63:0] prodIn;
   logic [2:0] sclKind;
   logic [NUM_REQ-1:0] othersDone;

   cycle_period_check u_cyc (
      .period(wrReq.data),
      .gran(gran),
      .periodOk(cycOk)
   );

   always_comb begin
      nxt_ff = cur_ff;
      nxt_ff.resp = '0;
      nxt_ff.chk = '0;
      nxt_ff.prevPhase = phase;
      reqHit = 1'b0;
      reqIx = 4'h0;
      for (int i = 0; i < NUM_REQ; i++) begin
         if (wrReq.pid == REQ_PID[i]) begin
            reqHit = 1'b1;
            reqIx = 4'(i);
         end
      end
      // stale values from an earlier run are never trusted
      if (phase == PHASE_TWO && cur_ff.prevPhase != PHASE_TWO) begin
         nxt_ff.pending = PEND_RST;
      end
      // required ones only in phase two, the rest in phase two or later
      phaseOk = (phase == PHASE_TWO) || (phase >= PHASE_THREE && !reqHit);
      othersDone = nxt_ff.pending;
      othersDone[CHK_IX] = 1'b0;
      if (wrReq.valid) begin
         if (!phaseOk) begin
            nxt_ff.resp.reject = 1'b1;
         end else if (wrReq.pid == PID_COMM_CYC && !cycOk) begin
            nxt_ff.resp.reject = 1'b1;
         end else if (wrReq.pid == PID_PH3_CHECK) begin
            nxt_ff.resp.ack = 1'b1;
            if (othersDone == '0) begin
               nxt_ff.chk.pass = 1'b1;
               nxt_ff.pending[CHK_IX] = 1'b0;
            end else begin
               nxt_ff.chk.fail = 1'b1;
            end
         end else begin
            nxt_ff.resp.ack = 1'b1;
            if (reqHit) begin
               nxt_ff.pending[reqIx] = 1'b0;
            end
            unique case (wrReq.pid)
               PID_COMM_CYC: begin
                  nxt_ff.commCyc = wrReq.data;
               end
               PID_CTL_CYC: begin
                  nxt_ff.ctlCyc = wrReq.data;
               end
               PID_POS_TYPE: begin
                  nxt_ff.posType = wrReq.data[15:0];
               end
               PID_POS_FACTOR: begin
                  nxt_ff.posFactor = wrReq.data;
               end
               PID_POS_EXP: begin
                  nxt_ff.posExp = wrReq.data[15:0];
               end
               default: begin
               end
            endcase
         end
      end
      // list entries are drawn from the required table only
      nxt_ff.firstInvalid = 16'h0000;
      for (int i = NUM_REQ - 1; i >= 0; i--) begin
         if (nxt_ff.pending[i]) begin
            nxt_ff.firstInvalid = REQ_PID[i];
         end
      end
      nxt_ff.listEmpty = (nxt_ff.pending == '0);

      // weight of one lsb expressed in internal nanometre units
      sclKind = cur_ff.posType[SCL_TYPE_LSB +: 3];
      if (cur_ff.posType[SCL_UNIT_BIT]) begin
         powIdx = cur_ff.posExp + INT_EXP_INCH;
      end else begin
         powIdx = cur_ff.posExp + INT_EXP_METRE;
      end
      // exponents finer than the internal unit saturate at 10^0; the factor and inch multiplier still apply
      if (powIdx[15]) begin
         powIdx = 16'h0000;
      end else if (powIdx > 16'(POW_MAX)) begin
         powIdx = 16'(POW_MAX);
      end
      pow = 64'h0000_0000_0000_0001;
      for (int i = 0; i < POW_MAX; i++) begin
         if (16'(i) < powIdx) begin
            pow = 64'(pow * 64'h0000_0000_0000_000A);
         end
      end
      divisor = 64'(pow * {32'h0000_0000, cur_ff.posFactor});
      if (cur_ff.posType[SCL_UNIT_BIT]) begin
         divisor = 64'(divisor * {32'h0000_0000, INCH_MULT});
      end
      if (divisor == '0) begin
         divisor = 64'h0000_0000_0000_0001;
      end
      prodIn = 64'($signed(cmdPosIn) * $signed(divisor));
      // internal value keeps its full resolution; only the wire weight moves
      if (sclKind == SCL_LINEAR) begin
         nxt_ff.posToMaster = POS_W'($signed(64'($signed(internalPos))) /
            $signed(divisor));
         nxt_ff.cmdPosInternal = POS_W'(prodIn);
      end else if (sclKind == SCL_NONE) begin
         nxt_ff.posToMaster = internalPos;
         nxt_ff.cmdPosInternal = cmdPosIn;
      end else begin
         // rotational types are outside this block; pass untouched
         nxt_ff.posToMaster = internalPos;
         nxt_ff.cmdPosInternal = cmdPosIn;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         cur_ff <= '0;
         cur_ff.prevPhase <= 3'h0;
         cur_ff.pending <= PEND_RST;
         cur_ff.firstInvalid <= PID_CTL_CYC;
         cur_ff.posType <= POS_TYPE_RST;
         cur_ff.posFactor <= POS_FACTOR_RST;
         cur_ff.posExp <= POS_EXP_RST;
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   assign wrResp = cur_ff.resp;
   assign phaseChk = cur_ff.chk;
   assign invalidMask = cur_ff.pending;
   assign firstInvalid = cur_ff.firstInvalid;
   assign listEmpty = cur_ff.listEmpty;
   assign commCycle = cur_ff.commCyc;
   assign posToMaster = cur_ff.posToMaster;
   assign cmdPosInternal = cur_ff.cmdPosInternal;
endmodule

// >>> drive_cycle_param_asserts.sv
// port assertions for the parameter and cycle checker
// assumes bind onto drive_cycle_param, one clock domain
`timescale 1ns/10ps
module drive_cycle_param_asserts
   import drive_cycle_param_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [2:0] phase,
   input wire logic [1:0] gran,
   input wire param_wr_s wrReq,
   input wire wr_resp_s wrResp,
   input wire phase_chk_s phaseChk,
   input wire logic [NUM_REQ-1:0] invalidMask,
   input wire logic [15:0] firstInvalid,
   input wire logic listEmpty,
   input wire logic [31:0] commCycle
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   property p_req_ack;
      wrReq.valid && phase == PHASE_TWO && wrReq.pid != PID_COMM_CYC
         |=> wrResp.ack && !wrResp.reject;
   endproperty
   a_req_ack: assert property (p_req_ack) else $error("phase two write not acked");
   property p_late_ok;
      wrReq.valid && phase >= PHASE_THREE && wrReq.pid == PID_POS_TYPE |=> wrResp.ack;
   endproperty
   a_late_ok: assert property (p_late_ok) else $error("late write not acked");
   property p_late_req;
      wrReq.valid && phase >= PHASE_THREE && wrReq.pid == PID_TEL_TYPE |=> wrResp.reject;
   endproperty
   a_late_req: assert property (p_late_req) else $error("late required write taken");
   property p_bad_cyc;
      wrReq.valid && wrReq.pid == PID_COMM_CYC && wrReq.data == 32'h0000_003F
         |=> wrResp.reject && commCycle == $past(commCycle);
   endproperty
   a_bad_cyc: assert property (p_bad_cyc) else $error("bad period taken");
   property p_no_gran;
      wrReq.valid && wrReq.pid == PID_COMM_CYC && gran == GRAN_NONE && wrReq.data == 32'h0000_05DC
         |=> wrResp.reject;
   endproperty
   a_no_gran: assert property (p_no_gran) else $error("default granularity wrong");
   property p_chk_fail;
      wrReq.valid && wrReq.pid == PID_PH3_CHECK && phase == PHASE_TWO && invalidMask[9:0] != 0
         |=> phaseChk.fail && !phaseChk.pass && invalidMask[CHK_IX];
   endproperty
   a_chk_fail: assert property (p_chk_fail) else $error("check passed too early");
   property p_chk_pass;
      wrReq.valid && wrReq.pid == PID_PH3_CHECK && phase == PHASE_TWO && $stable(phase)
         && invalidMask[9:0] == 0 |=> phaseChk.pass ##0 !invalidMask[CHK_IX];
   endproperty
   a_chk_pass: assert property (p_chk_pass) else $error("check not passed");
   property p_first;
      !listEmpty |-> firstInvalid inside {REQ_PID};
   endproperty
   a_first: assert property (p_first) else $error("foreign entry in list");
   property p_empty;
      listEmpty == (invalidMask == 0) && listEmpty == (firstInvalid == 16'h0000);
   endproperty
   a_empty: assert property (p_empty) else $error("list empty flag wrong");
   property p_quiet;
      !wrReq.valid |=> !wrResp.ack && !wrResp.reject && !phaseChk.pass && !phaseChk.fail;
   endproperty
   a_quiet: assert property (p_quiet) else $error("answer without write");
endmodule

bind drive_cycle_param drive_cycle_param_asserts u_asserts (.core_clk(core_clk), .nrst(nrst),
   .phase(phase), .gran(gran), .wrReq(wrReq), .wrResp(wrResp), .phaseChk(phaseChk),
   .invalidMask(invalidMask), .firstInvalid(firstInvalid), .listEmpty(listEmpty),
   .commCycle(commCycle));

// >>> control_unit_model.sv
// control unit side: one parameter write per call
// assumes calls start 1 ns after a rising edge
`timescale 1ns/10ps
module control_unit_model
   import drive_cycle_param_pkg::*;
(
   input wire logic core_clk,
   output param_wr_s wrReq
);
   initial begin
      wrReq = '0;
   end
   // held through the taking edge; burst ends only by idle
   task automatic put(input logic [15:0] ident, input logic [31:0] data);
      wrReq = '{valid: 1'b1, pid: ident, data: data};
      @(posedge core_clk);
      #1;
   endtask
   // released data is scrambled so nothing relies on it
   task automatic idle();
      wrReq = '{valid: 1'b0, pid: ~wrReq.pid, data: ~wrReq.data};
   endtask
endmodule

// >>> testbench.sv
// scenario bench for the parameter and cycle checker
// assumes control_unit_model drives the write port
`timescale 1ns/10ps
module testbench
   import drive_cycle_param_pkg::*;
();
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [2:0] phase;
   logic [1:0] gran;
   param_wr_s wrReq;
   wr_resp_s wrResp;
   phase_chk_s phaseChk;
   logic [NUM_REQ-1:0] invalidMask;
   logic [15:0] firstInvalid;
   logic listEmpty;
   logic [31:0] commCycle, internalPos, posToMaster, cmdPosIn, cmdPosInternal;
   int num_errors = 0;
   int checks = 0;
   localparam logic [34:0] CYC_TAB [12] = '{{3'h1, 32'h3E}, {3'h0, 32'h5DC}, {3'h3, 32'hFDE8},
      {3'h2, 32'h101D0}, {3'h3, 32'h1F4}, {3'h5, 32'h5DC}, {3'h4, 32'h2EE}, {3'h7, 32'h2EE},
      {3'h6, 32'h3F}, {3'h6, 32'hFEE2}, {3'h5, 32'hFA}, {3'h2, 32'h0}};
   always #5 core_clk = ~core_clk;
   drive_cycle_param u_drive_cycle_param (.core_clk(core_clk), .nrst(nrst), .phase(phase),
      .gran(gran), .wrReq(wrReq), .wrResp(wrResp), .phaseChk(phaseChk),
      .invalidMask(invalidMask), .firstInvalid(firstInvalid), .listEmpty(listEmpty),
      .commCycle(commCycle), .internalPos(internalPos), .posToMaster(posToMaster),
      .cmdPosIn(cmdPosIn), .cmdPosInternal(cmdPosInternal));
   control_unit_model u_control_unit_model (.core_clk(core_clk), .wrReq(wrReq));
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] pid, input logic [31:0] data, input logic ok);
      u_control_unit_model.put(pid, data);
      cmp(wrResp.ack, ok);
      cmp(wrResp.reject, !ok);
   endtask
   task automatic step();
      u_control_unit_model.idle();
      @(posedge core_clk);
      #1;
   endtask
   task automatic pos(input logic [31:0] inP, cmdP, expM, expI);
      internalPos = inP;
      cmdPosIn = cmdP;
      @(posedge core_clk);
      #1;
      cmp(posToMaster, expM);
      cmp(cmdPosInternal, expI);
   endtask
   task automatic t_reset();
      cmp(invalidMask, PEND_RST);
      cmp(firstInvalid, PID_CTL_CYC);
      cmp(listEmpty, 32'h0000_0000);
      cmp(commCycle, 32'h0000_0000);
   endtask
   task automatic t_phase2();
      wr(PID_PH3_CHECK, 32'h0000_0000, 1'b1);
      cmp(phaseChk.fail, 1'b1);
      cmp(phaseChk.pass, 1'b0);
      // control unit cycle twice the comm cycle
      for (int i = 0; i < CHK_IX; i++) begin
         wr(REQ_PID[i], i == 1 ? 32'h0000_03E8 : 32'h0000_07D0, 1'b1);
         cmp(firstInvalid, REQ_PID[i + 1]);
      end
      cmp(invalidMask, 11'h400);
      wr(PID_PH3_CHECK, 32'h0000_0000, 1'b1);
      cmp(phaseChk.pass, 1'b1);
      step();
      cmp({listEmpty, firstInvalid}, 32'h1_0000);
      phase = PHASE_THREE;
      step();
      phase = PHASE_TWO;
      step();
      step();
      cmp(invalidMask, PEND_RST);
   endtask
   task automatic t_cycle();
      logic [31:0] last;
      last = 32'h0000_03E8;
      for (int i = 0; i < 12; i++) begin
         gran = CYC_TAB[i][34:33];
         wr(PID_COMM_CYC, CYC_TAB[i][31:0], CYC_TAB[i][32]);
         if (CYC_TAB[i][32]) last = CYC_TAB[i][31:0];
         cmp(commCycle, last);
         step();
      end
   endtask
   task automatic t_phase3();
      phase = 3'h1;
      wr(PID_POS_TYPE, 32'h0000_0000, 1'b0);
      phase = PHASE_THREE;
      wr(PID_TEL_TYPE, 32'h0000_0007, 1'b0);
      wr(PID_POS_TYPE, 32'h0000_0010, 1'b1);
      step();
      pos(32'hFFFF_CFC7, 32'h0000_0007, 32'hFFFF_CFC7, 32'h0000_0007);
      wr(PID_POS_TYPE, {16'h0000, POS_TYPE_RST}, 1'b1);
      step();
      pos(32'hFFFF_CFC7, 32'h0000_0007, 32'hFFFF_FF85, 32'h0000_02BC);
      wr(PID_POS_FACTOR, 32'h0000_0002, 1'b1);
      wr(PID_POS_EXP, 32'h0000_FFFA, 1'b1);
      step();
      pos(32'hFFFF_CFC7, 32'h0000_0007, 32'hFFFF_FFFA, 32'h0000_36B0);
      // inch unit: exponent finer than internal unit saturates; weight is 254 times factor 2, 508 units
      wr(PID_POS_TYPE, 32'h0000_0011, 1'b1);
      step();
      pos(32'hFFFF_CFC7, 32'h0000_0007, 32'hFFFF_FFE8, 32'h0000_0DE4);
   endtask
   task automatic t_rereset();
      nrst = 1'b0;
      step();
      cmp(cmdPosInternal, 32'h0000_0000);
      cmp(posToMaster, 32'h0000_0000);
      nrst = 1'b1;
      step();
      t_reset();
      pos(32'hFFFF_CFC7, 32'h0000_0007, 32'hFFFF_FF85, 32'h0000_02BC);
   endtask
   task automatic print_verdict();
      if (num_errors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #20000;
      num_errors++;
      print_verdict();
   end
   initial begin
      phase = PHASE_TWO;
      gran = GRAN_ONE;
      internalPos = '0;
      cmdPosIn = '0;
      repeat (16) @(posedge core_clk);
      #1;
      nrst = 1'b1;
      step();
      t_reset();
      t_phase2();
      t_cycle();
      t_phase3();
      t_rereset();
      print_verdict();
   end
endmodule
